/* File: adc_frontend_pkg.sv */
// Package: register map, field layout, codes and timing for the front end
package adc_frontend_pkg;
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'h02;
    localparam logic [7:0] ADDR_GAIN = 8'h03;
    localparam logic [7:0] ADDR_REFERENCE = 8'h05;
    localparam logic [7:0] RST_INPUT_SELECT = 8'h01;
    localparam logic [7:0] RST_GAIN = 8'h00;
    localparam logic [7:0] RST_REFERENCE = 8'h10;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int POS_SEL_LSB = 4;
    localparam int NEG_SEL_LSB = 0;
    localparam int SEL_WIDTH = 4;
    localparam int GAIN_LSB = 0;
    localparam int AMP_PWR_LSB = 3;
    localparam int REFCON_LSB = 0;
    localparam int REFSEL_LSB = 2;
    localparam int NEG_REFERENCE_BUFFER_OFF_BIT = 4;
    localparam int POS_REFERENCE_BUFFER_OFF_BIT = 5;
    localparam logic [1:0] AMP_OFF_BYPASS = 2'h0;
    localparam logic [1:0] AMP_ON = 2'h1;
    localparam logic [1:0] REF_ON_PD_OFF = 2'h1;
    localparam logic [1:0] REF_ALWAYS_ON = 2'h2;
    localparam logic [1:0] REFSEL_INTERNAL = 2'h2;
    localparam logic [2:0] GAIN_1 = 3'h0;
    localparam logic [2:0] GAIN_32 = 3'h5;
    localparam logic [2:0] GAIN_64 = 3'h6;
    localparam logic [2:0] GAIN_128 = 3'h7;
    localparam logic [1:0] SCALE_X1 = 2'h0;
    localparam logic [1:0] SCALE_X2 = 2'h1;
    localparam logic [1:0] SCALE_X4 = 2'h2;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BBM_PERIODS = 2;
    localparam int BBM_NS = BBM_PERIODS * CLK_PERIOD_NS;
    localparam int BBM_CYCLES_INT = (BBM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] BBM_CYCLES = BBM_CYCLES_INT[1:0];

    typedef enum logic [2:0] {
        MON_NONE = 3'h0,
        MON_OFFSET_SHORT = 3'h1,
        MON_TEMPERATURE = 3'h3,
        MON_AVDD_DIV4 = 3'h2,
        MON_DVDD_DIV4 = 3'h6,
        MON_BURNOUT = 3'h7
    } mon_t;

    typedef enum logic [1:0] {
        SW_CONNECTED = 2'h0,
        SW_BREAK = 2'h1
    } sw_state_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] input_channel_select;
        logic [7:0] amplifier_gain_setting;
        logic [7:0] reference_control;
        sw_state_t sw_state;
        logic [1:0] bbm_count;
        logic [3:0] applied_pos;
        logic [3:0] applied_neg;
        logic [7:0] rdata;
    } state_t;
endpackage

/* File: adc_frontend_config_control.sv */
// Input selection, amplifier and reference configuration for the ADC front end
//
// Overview of operation
// - Positive and negative amplifier inputs chosen independently by 4-bit fields.
// - Channel change: inputs tied to mid-supply for two clocks, then connected.
// - Monitors: offset short, temperature, supplies divided by 4, burn-out.
// - 3-bit gain field selects gain 1 through 128 in binary steps.
// - Power code 00 bypasses and powers down amplifier; 01 uses it.
// - Gains 64 and 128 run analog gain 32 plus digital scaling.
// - Amplifier bypass only takes effect when gain is set to 1.
// - Reference code 10 always on; code 01 off during power-down.
// - After reset the internal reference stays powered down.
// - Reference source code 10 selects the internal reference.
// - Reference buffer bits are active low: one disables the buffer.
module adc_frontend_config_control (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire adc_frontend_pkg::reg_req_t reg_req_in,
    input wire adc_frontend_pkg::mon_t monitor_select_in,
    input wire logic power_down_mode_in,
    output logic [7:0] reg_rdata_out,
    output logic [3:0] amp_pos_channel_out,
    output logic [3:0] amp_neg_channel_out,
    output logic amp_inputs_connected_out,
    output logic amp_inputs_midsupply_out,
    output logic channel_switching_out,
    output logic temp_sensor_route_out,
    output logic avdd_monitor_route_out,
    output logic dvdd_monitor_route_out,
    output logic burnout_enable_out,
    output logic [2:0] analog_gain_code_out,
    output logic [1:0] digital_scale_shift_out,
    output logic amp_powered_out,
    output logic amp_bypass_out,
    output logic internal_ref_on_out,
    output logic [1:0] ref_source_out,
    output logic internal_ref_selected_out,
    output logic pos_ref_buffer_en_out,
    output logic neg_ref_buffer_en_out
);
    import adc_frontend_pkg::*;

    state_t state_reg;
    state_t state_next;

    logic [3:0] new_pos;
    logic [3:0] new_neg;
    logic chan_write;
    logic chan_changed;
    logic [2:0] gain_field;
    logic [1:0] power_field;
    logic [1:0] refcon_field;
    logic [1:0] refsel_field;
    logic amp_in_use;
    logic offset_short;
    logic monitor_takes_inputs;

    assign new_pos = reg_req_in.wdata[POS_SEL_LSB +: SEL_WIDTH];
    assign new_neg = reg_req_in.wdata[NEG_SEL_LSB +: SEL_WIDTH];
    assign chan_write = reg_req_in.write
        && (reg_req_in.addr == ADDR_INPUT_SELECT);
    // Rewriting the same channels does not disturb a running conversion
    assign chan_changed = chan_write
        && (reg_req_in.wdata != state_reg.input_channel_select);

    always_comb begin
        state_next = state_reg;
        if (reg_req_in.write) begin
            case (reg_req_in.addr)
                ADDR_INPUT_SELECT: begin
                    state_next.input_channel_select = reg_req_in.wdata;
                end
                ADDR_GAIN: begin
                    state_next.amplifier_gain_setting = reg_req_in.wdata;
                end
                ADDR_REFERENCE: begin
                    state_next.reference_control = reg_req_in.wdata;
                end
                default: begin
                    state_next.rdata = state_reg.rdata;
                end
            endcase
        end
        // Read data is the value before a write in the same cycle
        if (reg_req_in.read) begin
            case (reg_req_in.addr)
                ADDR_INPUT_SELECT: begin
                    state_next.rdata = state_reg.input_channel_select;
                end
                ADDR_GAIN: begin
                    state_next.rdata = state_reg.amplifier_gain_setting;
                end
                ADDR_REFERENCE: begin
                    state_next.rdata = state_reg.reference_control;
                end
                default: begin
                    state_next.rdata = RDATA_UNMAPPED;
                end
            endcase
        end
        // Break before make; a change during the break restarts it
        case (state_reg.sw_state)
            SW_CONNECTED: begin
                if (chan_changed) begin
                    state_next.sw_state = SW_BREAK;
                    state_next.bbm_count = 2'h0;
                end
            end
            SW_BREAK: begin
                if (chan_changed) begin
                    state_next.bbm_count = 2'h0;
                end else if (state_reg.bbm_count == BBM_CYCLES - 2'h1) begin
                    state_next.sw_state = SW_CONNECTED;
                    state_next.applied_pos = state_reg.input_channel_select
                        [POS_SEL_LSB +: SEL_WIDTH];
                    state_next.applied_neg = state_reg.input_channel_select
                        [NEG_SEL_LSB +: SEL_WIDTH];
                end else begin
                    state_next.bbm_count = state_reg.bbm_count + 2'h1;
                end
            end
            default: begin
                state_next.sw_state = SW_CONNECTED;
                state_next.bbm_count = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg.input_channel_select <= RST_INPUT_SELECT;
            state_reg.amplifier_gain_setting <= RST_GAIN;
            state_reg.reference_control <= RST_REFERENCE;
            state_reg.sw_state <= SW_CONNECTED;
            state_reg.bbm_count <= 2'h0;
            state_reg.applied_pos <= RST_INPUT_SELECT[POS_SEL_LSB +: SEL_WIDTH];
            state_reg.applied_neg <= RST_INPUT_SELECT[NEG_SEL_LSB +: SEL_WIDTH];
            state_reg.rdata <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;

    // Any code, the common input included, is legal on either side
    assign amp_pos_channel_out = state_reg.applied_pos;
    assign amp_neg_channel_out = state_reg.applied_neg;

    assign offset_short = (monitor_select_in == MON_OFFSET_SHORT);
    assign monitor_takes_inputs = offset_short
        || (monitor_select_in == MON_TEMPERATURE)
        || (monitor_select_in == MON_AVDD_DIV4)
        || (monitor_select_in == MON_DVDD_DIV4);
    assign channel_switching_out = (state_reg.sw_state == SW_BREAK);
    // Pins are never connected while the break is running
    assign amp_inputs_connected_out = !channel_switching_out
        && !monitor_takes_inputs;
    assign amp_inputs_midsupply_out = channel_switching_out
        || offset_short;
    assign temp_sensor_route_out = !channel_switching_out
        && (monitor_select_in == MON_TEMPERATURE);
    assign avdd_monitor_route_out = !channel_switching_out
        && (monitor_select_in == MON_AVDD_DIV4);
    assign dvdd_monitor_route_out = !channel_switching_out
        && (monitor_select_in == MON_DVDD_DIV4);
    assign burnout_enable_out = amp_inputs_connected_out
        && (monitor_select_in == MON_BURNOUT);

    assign gain_field = state_reg.amplifier_gain_setting[GAIN_LSB +: 3];
    assign power_field = state_reg.amplifier_gain_setting[AMP_PWR_LSB +: 2];

    // Reserved power codes fall back to the amplifier in use, the safe
    // choice since it never extends the input range beyond the supplies
    always_comb begin
        amp_in_use = 1'b1;
        if (power_field == AMP_OFF_BYPASS && gain_field == GAIN_1) begin
            amp_in_use = 1'b0;
        end else if (power_field == AMP_ON) begin
            amp_in_use = 1'b1;
        end
    end

    assign amp_powered_out = amp_in_use;
    assign amp_bypass_out = !amp_in_use;

    always_comb begin
        analog_gain_code_out = gain_field;
        digital_scale_shift_out = SCALE_X1;
        if (amp_in_use) begin
            case (gain_field)
                GAIN_64: begin
                    analog_gain_code_out = GAIN_32;
                    digital_scale_shift_out = SCALE_X2;
                end
                GAIN_128: begin
                    analog_gain_code_out = GAIN_32;
                    digital_scale_shift_out = SCALE_X4;
                end
                default: begin
                    analog_gain_code_out = gain_field;
                    digital_scale_shift_out = SCALE_X1;
                end
            endcase
        end
    end

    assign refcon_field = state_reg.reference_control[REFCON_LSB +: 2];
    assign refsel_field = state_reg.reference_control[REFSEL_LSB +: 2];

    // Code 11 is left off rather than guessed at
    assign internal_ref_on_out = (refcon_field == REF_ALWAYS_ON)
        || (refcon_field == REF_ON_PD_OFF && !power_down_mode_in);
    assign ref_source_out = refsel_field;
    assign internal_ref_selected_out = (refsel_field == REFSEL_INTERNAL);
    assign pos_ref_buffer_en_out =
        !state_reg.reference_control[POS_REFERENCE_BUFFER_OFF_BIT];
    assign neg_ref_buffer_en_out =
        !state_reg.reference_control[NEG_REFERENCE_BUFFER_OFF_BIT];
endmodule // adc_frontend_config_control

/* File: adc_frontend_sva.sv */
// Assertion checker for the ADC front end configuration block
module adc_frontend_sva (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire adc_frontend_pkg::reg_req_t reg_req_in,
    input wire logic power_down_mode_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [3:0] amp_pos_channel_out,
    input wire logic [3:0] amp_neg_channel_out,
    input wire logic amp_inputs_connected_out,
    input wire logic channel_switching_out,
    input wire logic [2:0] analog_gain_code_out,
    input wire logic [1:0] digital_scale_shift_out,
    input wire logic amp_bypass_out,
    input wire logic internal_ref_on_out,
    input wire logic pos_ref_buffer_en_out
);
    import adc_frontend_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    logic wr_sel, wr_gain, wr_ref, rd_hole;
    assign wr_sel = reg_req_in.write && reg_req_in.addr == ADDR_INPUT_SELECT;
    assign wr_gain = reg_req_in.write && reg_req_in.addr == ADDR_GAIN;
    assign wr_ref = reg_req_in.write && reg_req_in.addr == ADDR_REFERENCE;
    assign rd_hole = reg_req_in.read && !(reg_req_in.addr inside
        {ADDR_INPUT_SELECT, ADDR_GAIN, ADDR_REFERENCE});
    // Outside a break the applied channels equal the register
    sequence chan_change;
        wr_sel && !channel_switching_out &&
            reg_req_in.wdata != {amp_pos_channel_out, amp_neg_channel_out};
    endsequence
    sequence break_two;
        channel_switching_out[*2];
    endsequence
    a_change_breaks: assert property (chan_change |=> break_two)
        else $error("channel change without two-cycle break");
    a_break_isolates: assert property (channel_switching_out |->
        !amp_inputs_connected_out) else $error("inputs connected in break");
    a_apply_at_end: assert property (($changed(amp_pos_channel_out) ||
        $changed(amp_neg_channel_out)) |-> $fell(channel_switching_out))
        else $error("channels applied outside break end");
    a_unmapped_read: assert property (rd_hole |=>
        reg_rdata_out == RDATA_UNMAPPED) else $error("unmapped read not zero");
    a_high_gain_split: assert property (wr_gain &&
        reg_req_in.wdata[4:0] == {AMP_ON, GAIN_128} |=>
        analog_gain_code_out == GAIN_32 && digital_scale_shift_out == SCALE_X4)
        else $error("gain 128 not split");
    a_bypass_gain_one: assert property (amp_bypass_out |->
        analog_gain_code_out == GAIN_1 && digital_scale_shift_out == SCALE_X1)
        else $error("bypass at gain other than 1");
    a_ref_pd_drop: assert property (wr_ref &&
        reg_req_in.wdata[1:0] == REF_ON_PD_OFF ##1 power_down_mode_in |->
        !internal_ref_on_out) else $error("reference on in power-down");
    a_buf_active_low: assert property (wr_ref |=>
        pos_ref_buffer_en_out != $past(reg_req_in.wdata[POS_REFERENCE_BUFFER_OFF_BIT]))
        else $error("buffer control polarity");
endmodule // adc_frontend_sva

bind adc_frontend_config_control adc_frontend_sva sva_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_req_in(reg_req_in),
    .power_down_mode_in(power_down_mode_in), .reg_rdata_out(reg_rdata_out),
    .amp_pos_channel_out(amp_pos_channel_out),
    .amp_neg_channel_out(amp_neg_channel_out),
    .amp_inputs_connected_out(amp_inputs_connected_out),
    .channel_switching_out(channel_switching_out),
    .analog_gain_code_out(analog_gain_code_out),
    .digital_scale_shift_out(digital_scale_shift_out),
    .amp_bypass_out(amp_bypass_out), .internal_ref_on_out(internal_ref_on_out),
    .pos_ref_buffer_en_out(pos_ref_buffer_en_out));

/* File: adc_frontend_config_control_test.sv */
// Self-checking testbench for the ADC front end configuration block
module adc_frontend_config_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import adc_frontend_pkg::*;
    logic clk, rstn, pd, conn, mid, sw, temp, avdd, dvdd, burn, pwr, byp;
    logic ref_on, int_sel, pbuf, nbuf;
    logic [7:0] rdata;
    logic [3:0] pos_ch, neg_ch;
    logic [2:0] gain_c;
    logic [1:0] scale, ref_src;
    reg_req_t req;
    mon_t mon;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'hA7A4;
    // Monitor code in [7:5], expected temp/avdd/dvdd/burn/mid in [4:0]
    logic [7:0] mon_tab [5] = '{8'h21, 8'h70, 8'h48, 8'hC4, 8'hE2};
    adc_frontend_config_control DUT (.clk_in(clk), .rstn_in(rstn),
        .reg_req_in(req), .monitor_select_in(mon), .power_down_mode_in(pd),
        .reg_rdata_out(rdata), .amp_pos_channel_out(pos_ch),
        .amp_neg_channel_out(neg_ch), .amp_inputs_connected_out(conn),
        .amp_inputs_midsupply_out(mid), .channel_switching_out(sw),
        .temp_sensor_route_out(temp), .avdd_monitor_route_out(avdd),
        .dvdd_monitor_route_out(dvdd), .burnout_enable_out(burn),
        .analog_gain_code_out(gain_c), .digital_scale_shift_out(scale),
        .amp_powered_out(pwr), .amp_bypass_out(byp),
        .internal_ref_on_out(ref_on), .ref_source_out(ref_src),
        .internal_ref_selected_out(int_sel), .pos_ref_buffer_en_out(pbuf),
        .neg_ref_buffer_en_out(nbuf));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Packs {powered, bypass, 0, analog gain, digital scale}
    function automatic logic [7:0] amp_exp(input logic [7:0] v);
        logic use_amp;
        use_amp = !(v[4:3] == AMP_OFF_BYPASS && v[2:0] == GAIN_1);
        return {use_amp, !use_amp, 1'b0, (v[2:0] > GAIN_32) ? GAIN_32 : v[2:0],
            (v[2:0] == GAIN_64) ? SCALE_X2 :
            (v[2:0] == GAIN_128) ? SCALE_X4 : SCALE_X1};
    endfunction
    function automatic logic [7:0] ref_exp(input logic [7:0] v, input logic p);
        return {v[1:0] == REF_ALWAYS_ON || (v[1:0] == REF_ON_PD_OFF && !p),
            v[3:2] == REFSEL_INTERNAL, v[3:2], !v[5], !v[4], 2'b00};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Each access leaves a spare cycle so strobes never re-rise in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req.write = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req.read = 1'b0;
        check(rdata, exp);
        @(negedge clk);
    endtask
    task automatic finish_test();
        $display("samples_checked=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2000000;
        errors++;
        finish_test();
    end
    initial begin
        logic [7:0] v, ch;
        {rstn, pd, req, mon} = '0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        check({5'h0, ref_on, pbuf, nbuf}, 8'h02);
        rd(ADDR_INPUT_SELECT, RST_INPUT_SELECT);
        rd(ADDR_GAIN, RST_GAIN);
        rd(ADDR_REFERENCE, RST_REFERENCE);
        wr(8'h04, 8'hFF);
        rd(8'h04, RDATA_UNMAPPED);
        ch = RST_INPUT_SELECT;
        for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? ch : 8'(rnd());
            wr(ADDR_INPUT_SELECT, v);
            check({4'h0, sw, mid, conn, 1'b0}, (v != ch) ? 8'h0C : 8'h02);
            check({pos_ch, neg_ch}, ch);
            @(negedge clk);
            check({6'h0, sw, conn}, 8'h01);
            check({pos_ch, neg_ch}, v);
            ch = v;
        end
        foreach (mon_tab[k]) begin
            mon = mon_t'(mon_tab[k][7:5]);
            @(negedge clk);
            check({3'h0, temp, avdd, dvdd, burn, mid}, {3'h0, mon_tab[k][4:0]});
        end
        mon = MON_NONE;
        for (int i = 0; i < 16; i++) begin
            // Power codes 10 and 11 are reserved, so only 00 and 01 go out
            v = {3'(rnd()), 1'b0, i[0], i[3:1]};
            wr(ADDR_GAIN, v);
            check({pwr, byp, 1'b0, gain_c, scale}, amp_exp(v));
            rd(ADDR_GAIN, v);
        end
        for (int i = 0; i < 16; i++) begin
            v = (i < 8) ? {6'h0, i[2:1]} : 8'(rnd());
            pd = (i < 8) ? i[0] : 1'(rnd());
            // No conversion or excitation current is started here
            wr(ADDR_REFERENCE, v);
            check({ref_on, int_sel, ref_src, pbuf, nbuf, 2'b00}, ref_exp(v, pd));
            rd(ADDR_REFERENCE, v);
        end
        finish_test();
    end
endmodule // adc_frontend_config_control_test
